/* File: bench/cdc_checker.sv */
// checker: port-level assertions for the completion and chain controller
`timescale 1ns/1ns
`default_nettype none
module cdc_checker (
   // clock, reset and controls
   input wire logic core_clk_in, rst_in, active_serial_mode_in, chip_enable_in_n,
   input wire logic reconfigure_request_n_in, scan_program_req_in, load_error_in,
   // status and serial memory
   input wire logic completion_line_in, completion_line_oe_out, error_status_line_oe_out,
   input wire logic chain_enable_out_n, scan_program_ok_out, data_strobe_out,
   input wire logic user_mode_out, load_clock_out, memory_select_out_n
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence seq_init_start;
      $fell(completion_line_oe_out);
   endsequence
   // six cycles covers the three-stage filter plus the state register
   sequence seq_enable_off;
      chip_enable_in_n [*6];
   endsequence
   load_hold_a:
      assert property (data_strobe_out |-> completion_line_oe_out) else $error("early release");
   clean_release_a:
      assert property (seq_init_start |-> !error_status_line_oe_out && !user_mode_out)
         else $error("bad release");
   init_wait_a:
      assert property (!completion_line_in && !user_mode_out |=> !user_mode_out)
         else $error("user mode with line low");
   user_keep_a:
      assert property (user_mode_out && reconfigure_request_n_in |=> user_mode_out)
         else $error("user mode lost");
   chain_flag_a:
      assert property (chain_enable_out_n == !user_mode_out) else $error("chain output wrong");
   select_mode_a:
      assert property (!memory_select_out_n |-> active_serial_mode_in) else $error("select off mode");
   enable_gate_a:
      assert property (seq_enable_off |-> memory_select_out_n && !data_strobe_out)
         else $error("active while disabled");
   error_pull_a:
      assert property (data_strobe_out && load_error_in |-> ##[1:3] error_status_line_oe_out)
         else $error("error not flagged");
   clock_idle_a:
      assert property (!active_serial_mode_in |-> load_clock_out) else $error("load clock moved");
   scan_gate_a:
      assert property (seq_enable_off |-> !scan_program_ok_out) else $error("scan allowed");
endmodule // cdc_checker
bind cdc_config_done_chain cdc_checker i_cdc_checker (.*);
`default_nettype wire

/* File: bench/cdc_config_done_chain_tb.sv */
// testbench: load, hand-over, user mode, error and scan gating
`timescale 1ns/1ns
`default_nettype none
module cdc_config_done_chain_tb;
   localparam int IMG = 8;
   logic clk, rst, as_mode, ce_n, reconf_n, scan_req, load_err, hold_done, hold_err;
   logic done_line, err_line, data_bit, chain_n, scan_ok, done_oe, err_oe, strobe, user;
   logic lclk, cmd, cs_n;
   logic [31:0] cmd_word;
   int errors = 0;
   int n_compared = 0;
   int cnt, i;
   cdc_config_done_chain #(.LOAD_DIV(1), .IMAGE_BITS(IMG), .INIT_CYCLES(2)) i_cdc_config_done_chain (
      .core_clk_in(clk), .rst_in(rst), .active_serial_mode_in(as_mode),
      .chip_enable_in_n(ce_n), .reconfigure_request_n_in(reconf_n),
      .scan_program_req_in(scan_req), .chain_enable_out_n(chain_n), .scan_program_ok_out(scan_ok),
      .completion_line_in(done_line), .completion_line_out(), .completion_line_oe_out(done_oe),
      .error_status_line_in(err_line), .error_status_line_out(), .error_status_line_oe_out(err_oe),
      .load_error_in(load_err), .data_bit_in(data_bit), .data_strobe_out(strobe),
      .data_bit_out(), .user_mode_out(user), .load_clock_out(lclk),
      .serial_command_out(cmd), .memory_select_out_n(cs_n));
   cdc_far_model i_cdc_far_model (.clk_in(clk), .clr_in(rst), .done_oe_in(done_oe),
      .err_oe_in(err_oe), .hold_done_in(hold_done), .hold_err_in(hold_err), .cs_n_in(cs_n),
      .load_clk_in(lclk), .cmd_in(cmd), .done_line_out(done_line), .err_line_out(err_line),
      .data_bit_out(data_bit), .cmd_word_out(cmd_word));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic wait_for(input int lim, ref logic sig);
      int k;
      for (k = 0; k < lim && sig !== 1'b1; k++) tick(1);
      if (k == lim) begin
         errors++;
         close_out();
      end
   endtask
   // pause stalls the load with enable high; the count must still come out whole
   task automatic run_load(input bit pause, output int strobes);
      int k;
      strobes = 0;
      reconf_n = 1'b0;
      tick(6);
      reconf_n = 1'b1;
      for (k = 0; k < 3000 && !(strobes > 0 && !done_oe); k++) begin
         tick(1);
         strobes += int'(strobe);
         if (pause && strobes == 3) begin
            ce_n = 1'b1;
            repeat (10) begin tick(1); strobes += int'(strobe); end
            ce_n = 1'b0;
            pause = 1'b0;
         end
      end
      if (k == 3000) begin errors++; close_out(); end
   endtask
   initial begin
      {rst, as_mode, ce_n, reconf_n, scan_req, load_err, hold_done, hold_err} = 8'h80;
      void'($urandom(32'h5A67FAEC));
      tick(16);
      rst = 1'b0;
      run_load(1'b0, cnt);
      check(cnt, IMG);
      hold_done = 1'b1;
      tick(20);
      check(user, 1'b0);
      hold_done = 1'b0;
      wait_for(200, user);
      check({chain_n, done_oe}, 2'h0);
      {hold_done, hold_err, load_err} = 3'h7;
      tick(10);
      check(user, 1'b1);
      {hold_done, hold_err, load_err} = 3'h0;
      for (i = 0; i < 8; i++) begin
         scan_req = 1'($urandom);
         tick(1);
         check(scan_ok, scan_req);
      end
      ce_n = 1'b1;
      tick(6);
      check(scan_ok, 1'b0);
      {ce_n, scan_req, rst, as_mode} = 4'h3;
      tick(2);
      rst = 1'b0;
      run_load(1'b1, cnt);
      check(cnt, IMG);
      check(cmd_word, {cdc_pkg::CDC_READ_OPCODE, 24'h000000});
      reconf_n = 1'b0;
      tick(6);
      reconf_n = 1'b1;
      wait_for(400, strobe);
      load_err = 1'b1;
      tick(1);
      load_err = 1'b0;
      tick(5);
      check({err_oe, done_oe, user}, 3'h6);
      run_load(1'b0, cnt);
      check(cnt, IMG);
      close_out();
   end
endmodule // cdc_config_done_chain_tb
`default_nettype wire

/* File: bench/cdc_far_model.sv */
// far side: pulled-up status wires and a serial memory capturing the read command
`timescale 1ns/1ns
`default_nettype none
module cdc_far_model (
   input wire logic clk_in, clr_in, done_oe_in, err_oe_in, hold_done_in, hold_err_in,
   input wire logic cs_n_in, load_clk_in, cmd_in,
   output logic done_line_out, err_line_out, data_bit_out,
   output logic [31:0] cmd_word_out
);
   logic [7:0] pat_reg;
   logic [5:0] cnt_reg;
   // open drain with pull-up: any party pulling low wins
   assign done_line_out = !(done_oe_in || hold_done_in);
   assign err_line_out = !(err_oe_in || hold_err_in);
   // data keeps changing so a stale bit never looks valid
   assign data_bit_out = pat_reg[0];
   always_ff @(posedge clk_in) begin
      pat_reg <= clr_in ? 8'hA5 : {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
   end
   // memory samples the command on rising load clock while selected
   always_ff @(posedge load_clk_in or posedge clr_in) begin
      if (clr_in) begin
         cnt_reg <= 6'h00;
      end else if (!cs_n_in && cnt_reg < 6'h20) begin
         cnt_reg <= cnt_reg + 6'h01;
         cmd_word_out <= {cmd_word_out[30:0], cmd_in};
      end
   end
endmodule // cdc_far_model
`default_nettype wire

/* File: verilog/cdc_config_done_chain.sv */
// module: completion line, chain enable and active-serial memory control
`timescale 1ns/1ns
`default_nettype none
module cdc_config_done_chain #(
   parameter int LOAD_DIV = cdc_pkg::CDC_LOAD_DIV_DEFAULT,
   parameter int IMAGE_BITS = cdc_pkg::CDC_IMAGE_BITS_DEFAULT,
   parameter int INIT_CYCLES = cdc_pkg::CDC_INIT_CYCLES_DEFAULT
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // mode and chain
   input wire logic active_serial_mode_in,
   input wire logic chip_enable_in_n,
   input wire logic reconfigure_request_n_in,
   input wire logic scan_program_req_in,
   output logic chain_enable_out_n,
   output logic scan_program_ok_out,
   // completion line, open drain
   input wire logic completion_line_in,
   output logic completion_line_out,
   output logic completion_line_oe_out,
   // error status line, open drain
   input wire logic error_status_line_in,
   output logic error_status_line_out,
   output logic error_status_line_oe_out,
   // loader side
   input wire logic load_error_in,
   input wire logic data_bit_in,
   output logic data_strobe_out,
   output logic data_bit_out,
   output logic user_mode_out,
   // serial memory
   output logic load_clock_out,
   output logic serial_command_out,
   output logic memory_select_out_n
);
   localparam int CMD_BITS = cdc_pkg::CDC_OPCODE_BITS + cdc_pkg::CDC_ADDR_BITS;

   initial begin
      if (LOAD_DIV < 1 || LOAD_DIV > 255 || IMAGE_BITS < 1 || IMAGE_BITS > 65535 - CMD_BITS
          || INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin
         $error("cdc_config_done_chain: parameter out of range");
      end
   end

   localparam logic [15:0] TOTAL_BITS = 16'(IMAGE_BITS + CMD_BITS);
   localparam logic [15:0] CMD_LAST = 16'(CMD_BITS);
   localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);
   localparam logic [7:0] DIV_LAST = 8'(LOAD_DIV - 1);
   localparam logic [CMD_BITS-1:0] CMD_WORD = {cdc_pkg::CDC_READ_OPCODE, 24'h000000};

   // filtered level: move once the second and third stages agree
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   cdc_pkg::cdc_state_reg_t s_reg;
   cdc_pkg::cdc_state_reg_t s_next;
   logic rise;
   logic fall;

   always_comb begin
      s_next = s_reg;
      s_next.data_strobe = 1'b0;
      s_next.done_sync = {s_reg.done_sync[1:0], completion_line_in};
      s_next.ce_sync = {s_reg.ce_sync[1:0], ~chip_enable_in_n};
      s_next.rcfg_sync = {s_reg.rcfg_sync[1:0], ~reconfigure_request_n_in};
      s_next.err_sync = {s_reg.err_sync[1:0], ~error_status_line_in};
      s_next.done_high = filt(s_reg.done_sync, s_reg.done_high);
      s_next.ce_low = filt(s_reg.ce_sync, s_reg.ce_low);
      s_next.rcfg_low = filt(s_reg.rcfg_sync, s_reg.rcfg_low);
      s_next.err_low = filt(s_reg.err_sync, s_reg.err_low);
      rise = 1'b0;
      fall = 1'b0;
      if (s_reg.div_cnt == DIV_LAST) begin
         s_next.div_cnt = 8'h00;
         rise = ~s_reg.clk_level;
         fall = s_reg.clk_level;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 8'h01;
      end
      unique case (s_reg.state)
         cdc_pkg::CDC_ST_RESET: begin
            s_next.done_oe = 1'b1;
            s_next.err_oe = 1'b0;
            s_next.chain_n = cdc_pkg::CDC_CHAIN_RESET;
            s_next.cs_n = 1'b1;
            s_next.clk_level = 1'b1;
            s_next.cmd_bit = 1'b1;
            s_next.bit_cnt = 16'h0000;
            s_next.user_mode = 1'b0;
            // release of the reconfigure request starts a load while chip enable is low
            if (!s_reg.rcfg_low && s_reg.ce_low) begin
               s_next.state = cdc_pkg::CDC_ST_LOAD;
            end
         end
         cdc_pkg::CDC_ST_LOAD: begin
            s_next.done_oe = 1'b1;
            if (!s_reg.ce_low) begin
               // enable lost: park, no memory select, no data
               s_next.cs_n = 1'b1;
               s_next.clk_level = 1'b1;
            end else if (active_serial_mode_in) begin
               s_next.cs_n = 1'b0;
               if (rise || fall) begin
                  s_next.clk_level = rise;
               end
               if (fall) begin
                  // command shifted out on falling edges
                  s_next.cmd_bit = (s_reg.bit_cnt < CMD_LAST) ?
                     CMD_WORD[CMD_BITS - 1 - 32'(s_reg.bit_cnt)] : 1'b1;
               end
               if (rise) begin
                  s_next.bit_cnt = s_reg.bit_cnt + 16'h0001;
                  if (s_reg.bit_cnt >= CMD_LAST) begin
                     s_next.data_strobe = 1'b1;
                     s_next.data_bit = data_bit_in;
                  end
               end
            end else begin
               // other schemes: pins free, each cycle counts as one bit
               s_next.cs_n = 1'b1;
               s_next.data_strobe = 1'b1;
               s_next.data_bit = data_bit_in;
               s_next.bit_cnt = s_reg.bit_cnt + 16'h0001;
            end
            if (s_reg.bit_cnt >= TOTAL_BITS || (!active_serial_mode_in
                && s_reg.bit_cnt >= TOTAL_BITS - CMD_LAST)) begin
               s_next.state = cdc_pkg::CDC_ST_WAIT_DONE;
               // count already complete: no extra bit on the closing cycle
               s_next.data_strobe = 1'b0;
               s_next.bit_cnt = s_reg.bit_cnt;
               s_next.cs_n = 1'b1;
               s_next.clk_level = 1'b1;
               s_next.done_oe = 1'b0; // error-free image: release
               s_next.init_cnt = 16'h0000;
            end
         end
         cdc_pkg::CDC_ST_WAIT_DONE: begin
            // others may hold the line low and delay init
            if (s_reg.done_high) begin
               s_next.state = cdc_pkg::CDC_ST_INIT;
            end
         end
         cdc_pkg::CDC_ST_INIT: begin
            s_next.init_cnt = s_reg.init_cnt + 16'h0001;
            if (s_reg.init_cnt == INIT_LAST) begin
               s_next.state = cdc_pkg::CDC_ST_USER;
               s_next.user_mode = 1'b1;
               s_next.chain_n = 1'b0;
            end
         end
         cdc_pkg::CDC_ST_USER: begin
            // completion and status lines are ignored here
            s_next.user_mode = 1'b1;
         end
         cdc_pkg::CDC_ST_ERROR: begin
            s_next.err_oe = 1'b1;
            s_next.done_oe = 1'b1;
            s_next.cs_n = 1'b1;
         end
         default: begin
            s_next.state = cdc_pkg::CDC_ST_RESET;
         end
      endcase
      if ((load_error_in || s_reg.err_low) && s_reg.state != cdc_pkg::CDC_ST_USER
          && s_reg.state != cdc_pkg::CDC_ST_RESET && s_reg.state != cdc_pkg::CDC_ST_ERROR) begin
         s_next.state = cdc_pkg::CDC_ST_ERROR;
         s_next.err_oe = 1'b1;
         s_next.done_oe = 1'b1;
         s_next.cs_n = 1'b1;
      end
      // request low in any state throws the image away
      if (s_reg.rcfg_low) begin
         s_next.state = cdc_pkg::CDC_ST_RESET;
         s_next.err_oe = 1'b0;
         s_next.done_oe = 1'b1;
         s_next.chain_n = 1'b1;
         s_next.user_mode = 1'b0;
         s_next.cs_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s_reg <= '0;
         s_reg.state <= cdc_pkg::CDC_ST_RESET;
         s_reg.done_oe <= 1'b1;
         s_reg.chain_n <= cdc_pkg::CDC_CHAIN_RESET;
         s_reg.cs_n <= 1'b1;
         s_reg.clk_level <= 1'b1;
         s_reg.cmd_bit <= 1'b1;
         s_reg.rcfg_low <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // scan programming gate registered with the enable level
   logic scan_ok_reg;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         scan_ok_reg <= 1'b0;
      end else begin
         scan_ok_reg <= scan_program_req_in & s_reg.ce_low;
      end
   end

   assign chain_enable_out_n = s_reg.chain_n;
   assign scan_program_ok_out = scan_ok_reg;
   assign completion_line_out = 1'b0;
   assign completion_line_oe_out = s_reg.done_oe;
   assign error_status_line_out = 1'b0;
   assign error_status_line_oe_out = s_reg.err_oe;
   assign data_strobe_out = s_reg.data_strobe;
   assign data_bit_out = s_reg.data_bit;
   assign user_mode_out = s_reg.user_mode;
   assign load_clock_out = s_reg.clk_level;
   assign serial_command_out = s_reg.cmd_bit;
   assign memory_select_out_n = s_reg.cs_n;
endmodule // cdc_config_done_chain
`default_nettype wire

/* File: verilog/cdc_pkg.sv */
// package: constants and types for the configuration done and chain controller
package cdc_pkg;
   localparam int CDC_LOAD_DIV_DEFAULT = 2;
   localparam int CDC_IMAGE_BITS_DEFAULT = 64;
   localparam int CDC_INIT_CYCLES_DEFAULT = 16;
   localparam logic [7:0] CDC_READ_OPCODE = 8'h03;
   localparam int CDC_OPCODE_BITS = 8;
   localparam int CDC_ADDR_BITS = 24;
   localparam logic CDC_CHAIN_RESET = 1'b1;

   typedef enum logic [2:0] {
      CDC_ST_RESET = 3'h0,
      CDC_ST_LOAD = 3'h1,
      CDC_ST_WAIT_DONE = 3'h3,
      CDC_ST_INIT = 3'h2,
      CDC_ST_USER = 3'h6,
      CDC_ST_ERROR = 3'h7
   } cdc_state_t;

   typedef struct packed {
      logic out;
      logic oe;
   } cdc_od_pin_t;

   typedef struct packed {
      cdc_state_t state;
      logic [2:0] done_sync;
      logic done_high;
      logic [2:0] ce_sync;
      logic ce_low;
      logic [2:0] rcfg_sync;
      logic rcfg_low;
      logic [2:0] err_sync;
      logic err_low;
      logic [15:0] bit_cnt;
      logic [15:0] init_cnt;
      logic [7:0] div_cnt;
      logic clk_level;
      logic done_oe;
      logic err_oe;
      logic chain_n;
      logic cmd_bit;
      logic cs_n;
      logic user_mode;
      logic data_strobe;
      logic data_bit;
   } cdc_state_reg_t;
endpackage : cdc_pkg
